// ---- core/sfp_consts.svh ----
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
// Functional notes
// - byte program: opcode 02h, 24-bit address, one data byte, chip select held low
// - data bytes go out most significant bit first, bit 7 down to bit 0
// - software must only program locations already erased to FFh
// - a write-latch-set frame precedes every program or erase frame; the code sends later word frames (ADh, no address) without one
// - word program: opcode ADh, address, even byte first then odd byte
// - later words: ADh plus two data bytes, no address
// - leave word mode with 04h, then 80h when busy output is on
// - 70h turns the serial output into a busy pin, sent before word mode
// - sector erase 20h with address, upper bits pick a 4 KByte sector
// - block erase 52h with address picks a 32 KByte block
// - block erase D8h with address picks a 64 KByte block
// - every opcode, address and data byte is eight serial clocks
`define SFP_WRITE_LATCH_SET_CMD 8'h06
`define SFP_WRITE_LATCH_CLEAR_CMD 8'h04
`define SFP_STATUS_READ_CMD 8'h05
`define SFP_BYTE_PROG_CMD 8'h02
`define SFP_AUTO_INC_CMD 8'hAD
`define SFP_BUSY_OUTPUT_ON_CMD 8'h70
`define SFP_BUSY_OUTPUT_OFF_CMD 8'h80
`define SFP_ERASE_4K_CMD 8'h20
`define SFP_ERASE_32K_CMD 8'h52
`define SFP_ERASE_64K_CMD 8'hD8
`define SFP_ERASE_CHIP_CMD 8'h60
`define SFP_ERASE_CHIP_ALT_CMD 8'hC7
`define SFP_DUMMY_BYTE 8'h00
`define SFP_TOP_ADDRESS 24'hFF_FFFF
`define SFP_ODD_BYTE 24'h00_0001
`define SFP_WORD_STEP 24'h00_0002
`define SFP_BUSY_BIT 0
`define SFP_LAST_BIT 3'h7
`define SFP_SCK_HALF 4'h4
`define SFP_CS_GAP 4'h4
`define SFP_SO_SETTLE 4'h5
`define SFP_REG_CTRL 3'h0
`define SFP_REG_ADDR 3'h1
`define SFP_REG_DATA 3'h2
`define SFP_REG_CFG 3'h3
`define SFP_REG_STAT 3'h4
`define SFP_CTRL_GO 4
`define SFP_CFG_HW 0
`define SFP_CFG_AUTO 1
`define SFP_CFG_ALT 2
`define SFP_STAT_ERR 2
`endif

// ---- core/sfp_pkg.sv ----
`default_nettype none
package sfp_pkg;
	typedef enum logic [3:0] {
		sfp_op_latch_set, sfp_op_latch_clear, sfp_op_status, sfp_op_byte_prog,
		sfp_op_aai_start, sfp_op_aai_next, sfp_op_aai_end, sfp_op_erase_4k,
		sfp_op_erase_32k, sfp_op_erase_64k, sfp_op_erase_chip, sfp_op_wait
	} sfp_op_t;
	typedef enum logic [2:0] {
		sfp_st_idle, sfp_st_frame, sfp_st_byte, sfp_st_gap, sfp_st_poll, sfp_st_hwwait
	} sfp_fsm_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic has_addr;
		logic [1:0] ndata;
		logic rx;
	} sfp_frame_t;
	typedef struct packed {
		logic [2:0] ff;
		logic val;
	} sfp_sync_st_t;
	typedef struct packed {
		logic busy;
		logic done;
		logic sck;
		logic mosi;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [2:0] bitn;
		logic [3:0] cnt;
	} sfp_shift_st_t;
	typedef struct packed {
		sfp_fsm_t fsm;
		sfp_op_t op;
		logic [1:0] step;
		logic [2:0] bidx;
		logic [2:0] blen;
		logic [3:0] cnt;
		logic fin;
		logic cs_n;
		logic sh_go;
		logic [7:0] sh_tx;
		logic [23:0] addr;
		logic [15:0] data;
		logic cfg_hw;
		logic cfg_auto;
		logic cfg_alt;
		logic auto_increment_word_program;
		logic aai_top;
		logic [23:0] aai_addr;
		logic busy_out;
		logic err;
		logic [7:0] stat;
		logic hold;
		logic [31:0] rdata;
	} sfp_ctrl_st_t;
endpackage
`default_nettype wire

// ---- core/sfp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfp_sync (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset
	input wire logic async_in, // pin from outside
	output logic level // filtered level
);
	sfp_pkg::sfp_sync_st_t q, n;
	always_comb
	begin
		n = q;
		n.ff = {q.ff[1:0], async_in};
		if (q.ff[1] == q.ff[2])
			n.val = q.ff[2];
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end
	assign level = q.val;
endmodule // sfp_sync
`default_nettype wire

// ---- core/sfp_shift.sv ----
`timescale 1ns/1ps
`include "sfp_consts.svh"
`default_nettype none
module sfp_shift (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset
	input wire logic start, // send one byte
	input wire logic [7:0] tx, // byte to send
	input wire logic miso, // synchronised serial output of the flash
	output logic sck, // serial clock, idles low
	output logic mosi, // serial data to the flash
	output logic done, // byte finished, one cycle
	output logic [7:0] rx // byte received
);
	sfp_pkg::sfp_shift_st_t q, n;
	always_comb
	begin
		n = q;
		n.done = 1'b0;
		if (!q.busy)
		begin
			if (start)
			begin
				n.busy = 1'b1;
				n.sh = tx;
				n.mosi = tx[7];
				n.bitn = 3'h0;
				n.cnt = `SFP_SCK_HALF - 4'h1;
				n.sck = 1'b0;
			end
		end
		else if (q.cnt != 4'h0)
			n.cnt = q.cnt - 4'h1;
		else
		begin
			n.cnt = `SFP_SCK_HALF - 4'h1;
			if (!q.sck)
				n.sck = 1'b1;
			else
			begin
				// sample late in the high phase, well after the synchroniser delay
				n.sck = 1'b0;
				n.rx = {q.rx[6:0], miso};
				if (q.bitn == `SFP_LAST_BIT)
				begin
					n.busy = 1'b0;
					n.done = 1'b1;
				end
				else
				begin
					n.bitn = q.bitn + 3'h1;
					n.sh = {q.sh[6:0], 1'b0};
					n.mosi = q.sh[6];
				end
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= n;
	end
	assign sck = q.sck;
	assign mosi = q.mosi;
	assign done = q.done;
	assign rx = q.rx;
endmodule // sfp_shift
`default_nettype wire

// ---- core/sfp_ctrl.sv ----
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "sfp_consts.svh"
`default_nettype none
module sfp_ctrl (
	input wire logic mclk, // 20 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic flash_cs_n, // chip select, active low
	output logic flash_sck, // serial clock
	output logic flash_mosi, // serial data to flash
	input wire logic flash_miso // serial output of flash
);
	sfp_pkg::sfp_ctrl_st_t q, n;
	logic so_level;
	logic sh_done;
	logic [7:0] sh_rx;

	sfp_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in(flash_miso),
		.level(so_level)
	);

	sfp_shift u_shift (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(q.sh_go),
		.tx(q.sh_tx),
		.miso(so_level),
		.sck(flash_sck),
		.mosi(flash_mosi),
		.done(sh_done),
		.rx(sh_rx)
	);

	function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd,
		logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction

	function automatic sfp_pkg::sfp_frame_t mk(logic [7:0] code, logic has_addr,
		logic [1:0] nd, logic rx);
		sfp_pkg::sfp_frame_t f;
		f.valid = 1'b1;
		f.code = code;
		f.has_addr = has_addr;
		f.ndata = nd;
		f.rx = rx;
		return f;
	endfunction

	// frame list of one job; opt is busy-output use for word mode entry and exit
	function automatic sfp_pkg::sfp_frame_t frame_of(sfp_pkg::sfp_op_t op,
		logic [1:0] step, logic opt, logic alt);
		sfp_pkg::sfp_frame_t f;
		logic [1:0] e;
		f = '0;
		e = opt ? step : 2'(step + 2'h1);
		case (op)
			sfp_pkg::sfp_op_latch_set:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
			sfp_pkg::sfp_op_latch_clear:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_CLEAR_CMD, 1'b0, 2'h0, 1'b0);
			sfp_pkg::sfp_op_status:
				if (step == 2'h0)
					f = mk(`SFP_STATUS_READ_CMD, 1'b0, 2'h0, 1'b1);
			sfp_pkg::sfp_op_byte_prog:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1)
					f = mk(`SFP_BYTE_PROG_CMD, 1'b1, 2'h1, 1'b0); // target erased by software first
			sfp_pkg::sfp_op_aai_start:
				if (e == 2'h0)
					f = mk(`SFP_BUSY_OUTPUT_ON_CMD, 1'b0, 2'h0, 1'b0);
				else if (e == 2'h1)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (e == 2'h2)
					f = mk(`SFP_AUTO_INC_CMD, 1'b1, 2'h2, 1'b0);
			sfp_pkg::sfp_op_aai_next:
				if (step == 2'h0)
					f = mk(`SFP_AUTO_INC_CMD, 1'b0, 2'h2, 1'b0);
			sfp_pkg::sfp_op_aai_end:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_CLEAR_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1 && opt)
					f = mk(`SFP_BUSY_OUTPUT_OFF_CMD, 1'b0, 2'h0, 1'b0);
			sfp_pkg::sfp_op_erase_4k:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1)
					f = mk(`SFP_ERASE_4K_CMD, 1'b1, 2'h0, 1'b0);
			sfp_pkg::sfp_op_erase_32k:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1)
					f = mk(`SFP_ERASE_32K_CMD, 1'b1, 2'h0, 1'b0);
			sfp_pkg::sfp_op_erase_64k:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1)
					f = mk(`SFP_ERASE_64K_CMD, 1'b1, 2'h0, 1'b0);
			sfp_pkg::sfp_op_erase_chip:
				if (step == 2'h0)
					f = mk(`SFP_WRITE_LATCH_SET_CMD, 1'b0, 2'h0, 1'b0);
				else if (step == 2'h1)
					f = mk(alt ? `SFP_ERASE_CHIP_ALT_CMD : `SFP_ERASE_CHIP_CMD,
						1'b0, 2'h0, 1'b0);
			default:
				f = '0;
		endcase
		return f;
	endfunction

	// byte b of a frame: opcode, address high to low, even data, odd data
	function automatic logic [7:0] tx_byte(sfp_pkg::sfp_frame_t f, logic [23:0] a,
		logic [15:0] d, logic [2:0] b);
		logic [47:0] v;
		logic [2:0] j;
		v = {f.code, a, d[7:0], d[15:8]};
		j = (f.has_addr || b == 3'h0) ? b : 3'(b + 3'h3);
		if (f.rx && b != 3'h0)
			return `SFP_DUMMY_BYTE;
		return 8'(v >> (6'h08 * 6'(3'h5 - j)));
	endfunction

	function automatic logic allowed(sfp_pkg::sfp_op_t op, logic auto_increment_word_program, logic bo,
		logic top);
		logic r;
		r = 1'b0;
		if (op > sfp_pkg::sfp_op_wait)
			r = 1'b0;
		else if (auto_increment_word_program)
			case (op)
				sfp_pkg::sfp_op_aai_next:
					r = !top;
				sfp_pkg::sfp_op_aai_end, sfp_pkg::sfp_op_latch_clear,
				sfp_pkg::sfp_op_wait:
					r = 1'b1;
				sfp_pkg::sfp_op_status:
					r = !bo;
				default:
					r = 1'b0;
			endcase
		else
			r = (op != sfp_pkg::sfp_op_aai_next);
		return r;
	endfunction

	function automatic logic needs_poll(sfp_pkg::sfp_op_t op, logic auto_wait);
		logic r;
		case (op)
			sfp_pkg::sfp_op_wait:
				r = 1'b1;
			sfp_pkg::sfp_op_byte_prog, sfp_pkg::sfp_op_aai_start,
			sfp_pkg::sfp_op_aai_next, sfp_pkg::sfp_op_erase_4k,
			sfp_pkg::sfp_op_erase_32k, sfp_pkg::sfp_op_erase_64k,
			sfp_pkg::sfp_op_erase_chip:
				r = auto_wait;
			default:
				r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb
	begin
		sfp_pkg::sfp_frame_t f;
		logic acc_wr;
		logic go_req;
		logic err_set;
		logic err_clr;
		logic [31:0] wm;
		logic [23:0] base;
		n = q;
		f = frame_of(q.op, q.step,
			(q.op == sfp_pkg::sfp_op_aai_end) ? q.busy_out : q.cfg_hw, q.cfg_alt);
		acc_wr = avs_write && !q.hold;
		go_req = 1'b0;
		err_set = 1'b0;
		err_clr = 1'b0;
		wm = 32'h0000_0000;
		base = 24'h00_0000;
		n.sh_go = 1'b0;
		n.hold = 1'b1;
		if ((avs_read || avs_write) && q.hold)
		begin
			n.hold = 1'b0;
			case (avs_address[4:2])
				`SFP_REG_CTRL: n.rdata = 32'(q.op);
				`SFP_REG_ADDR: n.rdata = 32'(q.addr);
				`SFP_REG_DATA: n.rdata = 32'(q.data);
				`SFP_REG_CFG: n.rdata = 32'({q.cfg_alt, q.cfg_auto, q.cfg_hw});
				`SFP_REG_STAT: n.rdata = 32'({so_level, q.stat, 4'h0, q.busy_out,
					q.err, q.auto_increment_word_program, q.fsm != sfp_pkg::sfp_st_idle});
				default: n.rdata = 32'h0000_0000;
			endcase
		end
		if (acc_wr)
		begin
			case (avs_address[4:2])
				`SFP_REG_CTRL:
					go_req = avs_byteenable[0] && avs_writedata[`SFP_CTRL_GO];
				`SFP_REG_ADDR:
				begin
					wm = be_merge(32'(q.addr), avs_writedata, avs_byteenable);
					if (q.fsm == sfp_pkg::sfp_st_idle)
						n.addr = wm[23:0];
					else
						err_set = 1'b1;
				end
				`SFP_REG_DATA:
				begin
					wm = be_merge(32'(q.data), avs_writedata, avs_byteenable);
					if (q.fsm == sfp_pkg::sfp_st_idle)
						n.data = wm[15:0];
					else
						err_set = 1'b1;
				end
				`SFP_REG_CFG:
					if (q.fsm != sfp_pkg::sfp_st_idle)
						err_set = 1'b1;
					else if (avs_byteenable[0])
					begin
						n.cfg_hw = avs_writedata[`SFP_CFG_HW];
						n.cfg_auto = avs_writedata[`SFP_CFG_AUTO];
						n.cfg_alt = avs_writedata[`SFP_CFG_ALT];
					end
				`SFP_REG_STAT:
					err_clr = avs_byteenable[0] && avs_writedata[`SFP_STAT_ERR];
				default:
					err_set = 1'b0;
			endcase
		end
		case (q.fsm)
			sfp_pkg::sfp_st_idle:
				if (go_req)
				begin
					if (allowed(sfp_pkg::sfp_op_t'(avs_writedata[3:0]), q.auto_increment_word_program,
						q.busy_out, q.aai_top))
					begin
						n.op = sfp_pkg::sfp_op_t'(avs_writedata[3:0]);
						n.step = 2'h0;
						n.fin = 1'b0;
						n.fsm = sfp_pkg::sfp_st_frame;
					end
					else
						err_set = 1'b1;
				end
			sfp_pkg::sfp_st_frame:
				if (f.valid)
				begin
					n.cs_n = 1'b0;
					n.bidx = 3'h0;
					n.blen = 3'(3'h1 + (f.has_addr ? 3'h3 : 3'h0) + {1'b0, f.ndata}
						+ {2'h0, f.rx});
					n.sh_go = 1'b1;
					n.sh_tx = tx_byte(f, q.addr, q.data, 3'h0);
					n.fsm = sfp_pkg::sfp_st_byte;
				end
				else if (!q.fin && needs_poll(q.op, q.cfg_auto))
				begin
					n.fin = 1'b1;
					n.cs_n = 1'b0;
					n.bidx = 3'h0;
					n.cnt = `SFP_SO_SETTLE;
					if (q.auto_increment_word_program && q.busy_out)
						n.fsm = sfp_pkg::sfp_st_hwwait;
					else
					begin
						n.sh_go = 1'b1;
						n.sh_tx = `SFP_STATUS_READ_CMD;
						n.fsm = sfp_pkg::sfp_st_poll;
					end
				end
				else
					n.fsm = sfp_pkg::sfp_st_idle;
			sfp_pkg::sfp_st_byte:
				if (sh_done)
				begin
					if (f.rx && q.bidx != 3'h0)
						n.stat = sh_rx;
					if (q.bidx == 3'(q.blen - 3'h1))
					begin
						// rising chip select launches the operation in the flash
						n.cs_n = 1'b1;
						n.cnt = `SFP_CS_GAP;
						n.step = 2'(q.step + 2'h1);
						n.fsm = sfp_pkg::sfp_st_gap;
						case (f.code)
							`SFP_AUTO_INC_CMD:
							begin
								base = f.has_addr ? (q.addr & ~`SFP_ODD_BYTE) : q.aai_addr;
								n.auto_increment_word_program = 1'b1;
								n.aai_top = ((base | `SFP_ODD_BYTE) == `SFP_TOP_ADDRESS);
								n.aai_addr = base + `SFP_WORD_STEP;
							end
							`SFP_WRITE_LATCH_CLEAR_CMD:
							begin
								n.auto_increment_word_program = 1'b0;
								n.aai_top = 1'b0;
							end
							`SFP_BUSY_OUTPUT_ON_CMD:
								n.busy_out = 1'b1;
							`SFP_BUSY_OUTPUT_OFF_CMD:
								n.busy_out = 1'b0;
							default:
								n.auto_increment_word_program = q.auto_increment_word_program;
						endcase
					end
					else
					begin
						n.bidx = 3'(q.bidx + 3'h1);
						n.sh_go = 1'b1;
						n.sh_tx = tx_byte(f, q.addr, q.data, 3'(q.bidx + 3'h1));
					end
				end
			sfp_pkg::sfp_st_gap:
				if (q.cnt != 4'h0)
					n.cnt = q.cnt - 4'h1;
				else
					n.fsm = q.fin ? sfp_pkg::sfp_st_idle : sfp_pkg::sfp_st_frame;
			sfp_pkg::sfp_st_poll:
				if (sh_done)
				begin
					if (q.bidx != 3'h0)
						n.stat = sh_rx;
					n.bidx = 3'h1;
					if (q.bidx != 3'h0 && !sh_rx[`SFP_BUSY_BIT])
					begin
						n.cs_n = 1'b1;
						n.cnt = `SFP_CS_GAP;
						n.fsm = sfp_pkg::sfp_st_gap;
					end
					else
					begin
						// keep clocking: the status byte repeats while selected
						n.sh_go = 1'b1;
						n.sh_tx = `SFP_DUMMY_BYTE;
					end
				end
			sfp_pkg::sfp_st_hwwait:
				if (q.cnt != 4'h0)
					n.cnt = q.cnt - 4'h1;
				else if (so_level)
				begin
					n.cs_n = 1'b1;
					n.cnt = `SFP_CS_GAP;
					n.fsm = sfp_pkg::sfp_st_gap;
				end
			default:
				n.fsm = sfp_pkg::sfp_st_idle;
		endcase
		n.err = (q.err && !err_clr) || err_set;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.hold <= 1'b1;
			q.cs_n <= 1'b1;
		end
		else
			q <= n;
	end

	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.hold;
	assign flash_cs_n = q.cs_n;
endmodule // sfp_ctrl
`default_nettype wire

// ---- verification/sfp_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfp_ctrl_sva (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic avs_waitrequest, // stall
	input wire logic flash_cs_n, // chip select, active low
	input wire logic flash_sck, // serial clock
	input wire logic flash_mosi // serial data to flash
);
	logic sck_q;
	logic [2:0] nrise_q;
	// rising serial clock edges seen in the current frame, modulo one byte
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			sck_q <= 1'b0;
			nrise_q <= 3'h0;
		end
		else
		begin
			sck_q <= flash_sck;
			if (flash_cs_n)
				nrise_q <= 3'h0;
			else if (flash_sck && !sck_q)
				nrise_q <= nrise_q + 3'h1;
		end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_high_phase;
		flash_sck[*4] ##1 !flash_sck;
	endsequence
	sequence s_cs_lead;
		(!flash_sck)[*2];
	endsequence
	chk_sck_idle: assert property (flash_cs_n |-> !flash_sck)
		else $error("serial clock active outside a frame");
	chk_mosi_hold: assert property (flash_sck |-> $stable(flash_mosi))
		else $error("serial data moved while clock high");
	chk_sck_half: assert property ($rose(flash_sck) |-> (!flash_cs_n) throughout s_high_phase)
		else $error("clock high phase wrong or frame cut short");
	chk_frame_bytes: assert property ($rose(flash_cs_n) |-> nrise_q == 3'h0)
		else $error("frame ended inside a byte");
	chk_cs_gap: assert property ($rose(flash_cs_n) |-> flash_cs_n[*4])
		else $error("chip select gap too short");
	chk_cs_lead: assert property ($fell(flash_cs_n) |-> s_cs_lead)
		else $error("clock started with chip select");
	chk_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
endmodule // sfp_ctrl_sva
`default_nettype wire

// ---- verification/sfp_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfp_flash_model #(parameter int BUSY_NS = 3000) (
	input wire logic cs_n, // chip select, active low
	input wire logic sck, // serial clock from host
	input wire logic mosi, // serial data in
	output logic miso // serial data out
);
	logic [55:0] frames[$];
	logic [7:0] fb [0:5];
	logic [7:0] sh = 8'h00;
	logic [7:0] nb = 8'h00;
	logic [7:0] stat;
	logic [23:0] aai_a = 24'h00_0000;
	int nbit = 0;
	logic busy = 1'b0;
	logic write_latch_bit = 1'b0;
	logic auto_increment_word_program = 1'b0;
	logic bo = 1'b0;
	logic drv = 1'b0;
	logic dval = 1'b0;
	logic junk = 1'b0;
	logic prot = 1'b0; // no protected area set up, the drop paths stay idle
	assign stat = {1'b0, auto_increment_word_program, 4'h0, write_latch_bit, busy};
	always #50 junk = ~junk; // a released line never holds its last value
	assign miso = (!cs_n && bo && auto_increment_word_program) ? !busy : (!cs_n && drv) ? dval : junk;
	task automatic kick();
		busy = 1'b1;
		fork
			begin
				#(BUSY_NS);
				busy = 1'b0;
				if (!auto_increment_word_program)
					write_latch_bit = 1'b0;
			end
		join_none
	endtask
	always @(negedge cs_n)
	begin
		nb = 8'h00;
		nbit = 0;
		foreach (fb[i])
			fb[i] = 8'h00;
	end
	always @(posedge sck)
		if (!cs_n)
		begin
			sh = {sh[6:0], mosi};
			nbit++;
			if (nbit % 8 == 0)
			begin
				if (nb < 6)
					fb[nb] = sh;
				nb++;
			end
		end
	always @(negedge sck)
		if (!cs_n && fb[0] == 8'h05 && nb != 8'h00)
		begin
			drv = 1'b1;
			dval = stat[7 - (nbit % 8)];
		end
	always @(posedge cs_n)
	begin
		drv = 1'b0;
		frames.push_back({nb, fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]});
		if (nbit % 8 == 0 && (!auto_increment_word_program || fb[0] inside {8'hAD, 8'h04, 8'h05}))
			case (fb[0])
				8'h06: write_latch_bit = 1'b1;
				8'h04:
				begin
					write_latch_bit = 1'b0;
					auto_increment_word_program = 1'b0;
				end
				8'h70: bo = 1'b1;
				8'h80: bo = 1'b0;
				8'h02: if (write_latch_bit && nb == 5 && !prot) kick();
				8'h20, 8'h52, 8'hD8: if (write_latch_bit && nb == 4 && !prot) kick();
				8'h60, 8'hC7: if (write_latch_bit && nb == 1 && !prot) kick();
				8'hAD:
					if (write_latch_bit && !prot && (auto_increment_word_program ? nb == 3 && aai_a != 24'hFF_FFFE : nb == 6))
					begin
						aai_a = auto_increment_word_program ? aai_a + 24'h00_0002 : {fb[1], fb[2], fb[3]};
						auto_increment_word_program = 1'b1;
						kick();
					end
				default: ;
			endcase
	end
endmodule // sfp_flash_model
`default_nettype wire

// ---- verification/sfp_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`include "sfp_consts.svh"
`default_nettype none
module sfp_ctrl_tb_top;
	localparam logic [55:0] ALL = 56'hFF_FFFF_FFFF_FFFF;
	localparam logic [55:0] OPC = 56'h00_FF00_0000_0000;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, rv;
	logic avs_waitrequest, flash_cs_n, flash_sck, flash_mosi, flash_miso;
	int n_mismatch = 0;
	int n_tests = 0;
	logic [7:0] ecode [0:4] = '{`SFP_ERASE_4K_CMD, `SFP_ERASE_32K_CMD, `SFP_ERASE_64K_CMD,
		`SFP_ERASE_CHIP_CMD, `SFP_ERASE_CHIP_ALT_CMD};
	logic [3:0] eop [0:4] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hA};
	logic [3:0] bad [0:1] = '{4'hC, 4'h5};
	always #25 mclk = ~mclk;
	sfp_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flash_cs_n(flash_cs_n),
		.flash_sck(flash_sck), .flash_mosi(flash_mosi), .flash_miso(flash_miso));
	sfp_flash_model i_flash (.cs_n(flash_cs_n), .sck(flash_sck), .mosi(flash_mosi), .miso(flash_miso));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
		int i;
		i = 0;
		@(posedge mclk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 50);
		if (i >= 50)
		begin
			n_mismatch++;
			end_of_test();
		end
		rv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] idx, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, idx, 32'h0000_0000);
		cmp({24'h00_0000, rv & m}, {24'h00_0000, e});
	endtask
	task automatic op(input logic [3:0] code);
		int i;
		i = 0;
		bus(1'b1, `SFP_REG_CTRL, {27'h000_0000, 1'b1, code});
		do
		begin
			bus(1'b0, `SFP_REG_STAT, 32'h0000_0000);
			i++;
		end
		while (rv[0] !== 1'b0 && i < 2000);
		if (i >= 2000)
		begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic fr(input logic [55:0] m, input logic [55:0] e);
		logic [55:0] g;
		g = 'x;
		if (i_flash.frames.size() > 0)
			g = i_flash.frames.pop_front();
		cmp(g & m, e);
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		// chip select leaving unknown before reset logs a false frame in the model
		i_flash.frames.delete();
		rd(`SFP_REG_STAT, 32'h0000_FFFF, 32'h0000_0000);
		rd(`SFP_REG_CFG, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1'b1, 3'h5, 32'hFFFF_FFFF);
		rd(3'h5, 32'hFFFF_FFFF, 32'h0000_0000);
		op(4'h0);
		fr(ALL, 56'h01_0600_0000_0000);
		op(4'h2);
		fr(OPC, 56'h00_0500_0000_0000);
		rd(`SFP_REG_STAT, 32'h0000_FF00, 32'h0000_0200);
		op(4'h1);
		fr(ALL, 56'h01_0400_0000_0000);
		op(4'h2);
		rd(`SFP_REG_STAT, 32'h0000_FF00, 32'h0000_0000);
		i_flash.frames.delete();
		bus(1'b1, `SFP_REG_ADDR, 32'h0012_3456);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, `SFP_REG_CFG, (i == 4) ? 32'h0000_0006 : 32'h0000_0002);
			op(eop[i]);
			fr(ALL, 56'h01_0600_0000_0000);
			fr(ALL, (i < 3) ? {8'h04, ecode[i], 40'h12_3456_0000} : {8'h01, ecode[i], 40'h0});
			fr(OPC, 56'h00_0500_0000_0000);
			i_flash.frames.delete();
		end
		bus(1'b1, `SFP_REG_CFG, 32'h0000_0004);
		bus(1'b1, `SFP_REG_DATA, 32'h0000_00A5);
		op(4'h3);
		fr(ALL, 56'h01_0600_0000_0000);
		fr(ALL, 56'h05_0212_3456_A500);
		op(4'hB);
		fr(OPC, 56'h00_0500_0000_0000);
		op(4'h2);
		rd(`SFP_REG_STAT, 32'h0000_FF00, 32'h0000_0000);
		i_flash.frames.delete();
		bus(1'b1, `SFP_REG_CFG, 32'h0000_0002);
		bus(1'b1, `SFP_REG_ADDR, 32'h0012_0100);
		bus(1'b1, `SFP_REG_DATA, 32'h0000_3C5A);
		op(4'h4);
		fr(ALL, 56'h01_0600_0000_0000);
		fr(ALL, 56'h06_AD12_0100_5A3C);
		i_flash.frames.delete();
		rd(`SFP_REG_STAT, 32'h0000_0002, 32'h0000_0002);
		bus(1'b1, `SFP_REG_DATA, 32'h0000_7788);
		op(4'h5);
		fr(ALL, 56'h03_AD88_7700_0000);
		i_flash.frames.delete();
		op(4'h2);
		rd(`SFP_REG_STAT, 32'h0000_FF00, 32'h0000_4200);
		op(4'h6);
		i_flash.frames.delete();
		op(4'h2);
		rd(`SFP_REG_STAT, 32'h0000_FF02, 32'h0000_0000);
		i_flash.frames.delete();
		bus(1'b1, `SFP_REG_CFG, 32'h0000_0003);
		bus(1'b1, `SFP_REG_ADDR, 32'h0012_0200);
		op(4'h4);
		fr(ALL, 56'h01_7000_0000_0000);
		fr(ALL, 56'h01_0600_0000_0000);
		fr(ALL, 56'h06_AD12_0200_8877);
		fr(ALL, 56'h00_0000_0000_0000);
		rd(`SFP_REG_STAT, 32'h0000_000E, 32'h0000_000A);
		op(4'h2);
		cmp(56'(i_flash.frames.size()), 56'h00_0000_0000_0000);
		rd(`SFP_REG_STAT, 32'h0000_0004, 32'h0000_0004);
		bus(1'b1, `SFP_REG_STAT, 32'h0000_0004);
		op(4'h6);
		fr(ALL, 56'h01_0400_0000_0000);
		fr(ALL, 56'h01_8000_0000_0000);
		rd(`SFP_REG_STAT, 32'h0000_000E, 32'h0000_0000);
		for (int i = 0; i < 2; i++)
		begin
			op(bad[i]);
			rd(`SFP_REG_STAT, 32'h0000_0004, 32'h0000_0004);
			bus(1'b1, `SFP_REG_STAT, 32'h0000_0004);
			rd(`SFP_REG_STAT, 32'h0000_0004, 32'h0000_0000);
		end
		bus(1'b1, `SFP_REG_CFG, 32'h0000_0002);
		bus(1'b1, `SFP_REG_ADDR, 32'h00FF_FFFE);
		op(4'h4);
		fr(ALL, 56'h01_0600_0000_0000);
		fr(ALL, 56'h06_ADFF_FFFE_8877);
		i_flash.frames.delete();
		op(4'h5);
		cmp(56'(i_flash.frames.size()), 56'h00_0000_0000_0000);
		rd(`SFP_REG_STAT, 32'h0000_0004, 32'h0000_0004);
		op(4'h6);
		fr(ALL, 56'h01_0400_0000_0000);
		end_of_test();
	end
endmodule // sfp_ctrl_tb_top
bind sfp_ctrl sfp_ctrl_sva i_sva (.mclk(mclk), .rst_n(rst_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .flash_cs_n(flash_cs_n),
	.flash_sck(flash_sck), .flash_mosi(flash_mosi));
`default_nettype wire
